// [rtl/nsr_buf.sv]
/*
 Small synchronous FIFO with valid and ready on both sides, used in the
 sample path so a receiver stall loses no word.
 Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none

module nsr_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]   count, next_count;
   logic          push, pop;

   // handshakes straight from the fill level
   assign in_ready_o  = (count != FULL);
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // pointer and level update
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // storage needs no reset, its content is only read while valid
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

endmodule

`default_nettype wire

// [rtl/nsr_consts.svh]
/*
 Constants of the noise-shaping requantizer: widths, filter number
 ranges, center-frequency segment coefficients and reset values.
 Assumes it is included by its bare name before any use.
*/
// Notes on behaviour
// - requantizer has its own enable, independent of other functions.
// - separate short-word and long-word enables, each set by configuration.
// - active requantizer keeps 11 bits (short) or 12 bits (long).
// - quantization error is shaped so noise falls outside the chosen band.
// - 7-bit filter select field holds the filter number in plain binary.
// - filter number selects exactly one bandwidth and one center frequency.
// - short-word mode accepts filter numbers 0 through 41 only.
// - long-word mode accepts filter numbers 42 through 76 only.
// - short: 0-20 give 22 percent band, 21-41 give 25 percent band.
// - long: 42-62 give 25 percent band, 63-76 give 29 percent band.
// - disabled requantizer forwards samples unchanged.
// - a configuration bit clears the shaping state on overload.
`ifndef NSR_CONSTS_SVH
`define NSR_CONSTS_SVH

`define NSR_IN_W        16
`define NSR_SHORT_W     11
`define NSR_LONG_W      12
`define NSR_FSEL_W      7
`define NSR_BUF_DEPTH   2

// filter number segment bounds
`define NSR_S22_LO      7'h00
`define NSR_S22_HI      7'h14
`define NSR_S25_LO      7'h15
`define NSR_S25_HI      7'h29
`define NSR_L25_LO      7'h2A
`define NSR_L25_HI      7'h3E
`define NSR_L29_LO      7'h3F
`define NSR_L29_HI      7'h4C

// center / fs in Q16: base and step per filter number
`define NSR_B22_Q16     32'sd7864
`define NSR_T22_Q16     32'sd852
`define NSR_B25_Q16     32'sd8192
`define NSR_T25_Q16     32'sd819
`define NSR_B29_Q16     32'sd9830
`define NSR_T29_Q16     32'sd1092
`define NSR_QUARTER_Q16 32'sd16384
// two pi in Q12
`define NSR_TWO_PI_Q12  32'sd25736

// band width in percent of sample rate
`define NSR_BW22        5'h16
`define NSR_BW25        5'h19
`define NSR_BW29        5'h1D

// overload threshold, 0.9 of full scale in Q16
`define NSR_OVL_Q16     32'sd58982
`define NSR_COEF_FRAC   14

// reset values
`define NSR_COEF_RST    18'h00000
`define NSR_CENTER_RST  16'h0000
`define NSR_BW_RST      5'h00

`endif

// [rtl/nsr_core.sv]
/*
 Noise-shaping requantizer: second-order error feedback whose notch is
 placed at the center of the selected band, with bypass, range check,
 overload detection and a two-entry output buffer.
 Assumes samples and configuration come from logic on CORE_CLK_I.
*/
`include "nsr_consts.svh"
`default_nettype none

module nsr_core #(
   parameter int IN_W = `NSR_IN_W
) (
   input  wire logic                   CORE_CLK_I,
   input  wire logic                   RST_I,
   input  wire logic                   POST_PROCESSING_OPTIONS_EN_I,
   input  wire logic                   SHORT_WORD_EN_I,
   input  wire logic                   LONG_WORD_EN_I,
   input  wire logic [`NSR_FSEL_W-1:0] FILTER_SEL_I,
   input  wire logic                   RESET_ON_OVERLOAD_I,
   input  wire logic                   IN_VALID_I,
   input  wire logic [IN_W-1:0]        IN_DATA_I,
   output logic                        IN_READY_O,
   output logic                        OUT_VALID_O,
   output logic [IN_W-1:0]             OUT_DATA_O,
   output logic                        OUT_CLIPPED_O,
   input  wire logic                   OUT_READY_I,
   output nsr_pkg::nsr_mode_type       MODE_O,
   output logic [4:0]                  BAND_PCT_O,
   output logic [15:0]                 CENTER_O,
   output logic                        CONFIG_ERR_O,
   output logic                        OVERLOAD_O
);
   localparam int VW = IN_W + 4;
   localparam int CW = 18;

   // filter number to center / fs in Q16
   function automatic logic signed [31:0] center_of(
      input logic [`NSR_FSEL_W-1:0] n);
      logic signed [31:0] k;
      k = 32'(n);
      if (n <= `NSR_S22_HI) begin
         center_of = `NSR_B22_Q16 + `NSR_T22_Q16 * k;
      end else if (n <= `NSR_S25_HI) begin
         center_of = `NSR_B25_Q16 + `NSR_T25_Q16 * (k - 32'sd21);
      end else if (n <= `NSR_L25_HI) begin
         center_of = `NSR_B25_Q16 + `NSR_T25_Q16 * (k - 32'sd42);
      end else begin
         center_of = `NSR_B29_Q16 + `NSR_T29_Q16 * (k - 32'sd63);
      end
   endfunction

   // filter number to band width in percent
   function automatic logic [4:0] band_of(
      input logic [`NSR_FSEL_W-1:0] n);
      if (n <= `NSR_S22_HI) begin
         band_of = `NSR_BW22;
      end else if (n <= `NSR_L25_HI) begin
         band_of = `NSR_BW25;
      end else begin
         band_of = `NSR_BW29;
      end
   endfunction

   // notch coefficient 2cos(2 pi f) in Q14, via -2 sin of the offset
   // from fs/4; the cubic term is enough over the 0.12..0.38 span
   function automatic logic signed [CW-1:0] coef_of(
      input logic signed [31:0] f_q16);
      logic signed [31:0] u;
      logic signed [31:0] x;
      logic signed [63:0] x3;
      logic signed [31:0] s;
      u  = f_q16 - `NSR_QUARTER_Q16;
      x  = (u * `NSR_TWO_PI_Q12) >>> 12;
      x3 = 64'(x) * 64'(x) * 64'(x);
      s  = x - 32'(x3 / 64'sd25769803776);
      coef_of = CW'(-(s >>> 1));
   endfunction

   nsr_pkg::nsr_mode_type mode, next_mode;
   logic signed [CW-1:0]  coef, next_coef;
   logic [4:0]            band, next_band;
   logic [15:0]           center, next_center;
   logic                  cfg_err, next_cfg_err;
   logic signed [VW-1:0]  e1, e2, next_e1, next_e2;
   logic                  ovl, next_ovl;

   logic                  fsel_ok;
   logic                  take;
   logic                  buf_ready;
   nsr_pkg::nsr_sample_type shaped, buf_out;

   // configuration decode, registered so the coefficient math is off
   // the sample path; a mode change costs one sample of old settings
   always_comb begin
      next_mode    = nsr_pkg::NSR_BYPASS;
      fsel_ok      = 1'b0;
      if (POST_PROCESSING_OPTIONS_EN_I) begin
         if (SHORT_WORD_EN_I && LONG_WORD_EN_I) begin
            next_mode = nsr_pkg::NSR_BAD;
         end else if (SHORT_WORD_EN_I) begin
            next_mode = nsr_pkg::NSR_SHORT;
         end else if (LONG_WORD_EN_I) begin
            next_mode = nsr_pkg::NSR_LONG;
         end
      end
      case (next_mode)
         nsr_pkg::NSR_SHORT: fsel_ok = FILTER_SEL_I <= `NSR_S25_HI;
         nsr_pkg::NSR_LONG:  fsel_ok = (FILTER_SEL_I >= `NSR_L25_LO) &&
                                       (FILTER_SEL_I <= `NSR_L29_HI);
         nsr_pkg::NSR_BYPASS: fsel_ok = 1'b1;
         default:            fsel_ok = 1'b0;
      endcase
      next_cfg_err = !fsel_ok;
      next_center  = 16'(center_of(FILTER_SEL_I));
      next_band    = band_of(FILTER_SEL_I);
      next_coef    = coef_of(center_of(FILTER_SEL_I));
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         mode    <= nsr_pkg::NSR_BYPASS;
         coef    <= `NSR_COEF_RST;
         band    <= `NSR_BW_RST;
         center  <= `NSR_CENTER_RST;
         cfg_err <= 1'b0;
      end else begin
         mode    <= next_mode;
         coef    <= next_coef;
         band    <= next_band;
         center  <= next_center;
         cfg_err <= next_cfg_err;
      end
   end

   // error-feedback requantizer, noise transfer 1 - c z^-1 + z^-2
   always_comb begin
      logic signed [VW-1:0]    x;
      logic signed [CW+VW-1:0] prod;
      logic signed [VW-1:0]    v;
      logic signed [VW-1:0]    q;
      logic signed [VW-1:0]    y;
      logic signed [VW-1:0]    e;
      logic signed [VW-1:0]    half;
      logic signed [VW-1:0]    mask;
      logic signed [VW-1:0]    vmax;
      logic signed [VW-1:0]    vmin;
      logic signed [VW-1:0]    thr;
      logic                    clip;
      logic                    big;
      int                      drop;
      x    = VW'(signed'(IN_DATA_I));
      prod = (CW+VW)'(coef) * (CW+VW)'(e1);
      v    = x - VW'(prod >>> `NSR_COEF_FRAC) + e2;
      drop = (mode == nsr_pkg::NSR_SHORT) ? IN_W - `NSR_SHORT_W
                                          : IN_W - `NSR_LONG_W;
      half = VW'(1) <<< (drop - 1);
      mask = ~((VW'(1) <<< drop) - VW'(1));
      vmax = (VW'(1) <<< (IN_W - 1)) - (VW'(1) <<< drop);
      vmin = -(VW'(1) <<< (IN_W - 1));
      q    = (v + half) & mask;
      clip = 1'b0;
      y    = q;
      if (q > vmax) begin
         y    = vmax;
         clip = 1'b1;
      end else if (q < vmin) begin
         y    = vmin;
         clip = 1'b1;
      end
      e = y - v;
      // clamp so a clipped sample cannot wind up the feedback
      if (e > half) begin
         e = half;
      end else if (e < -half) begin
         e = -half;
      end
      thr  = VW'((64'sd1 <<< (IN_W - 1)) * 64'(`NSR_OVL_Q16) >>> 16);
      big  = (x > thr) || (x < -thr);
      next_e1  = e1;
      next_e2  = e2;
      next_ovl = 1'b0;
      shaped.data    = IN_DATA_I;
      shaped.clipped = 1'b0;
      if (mode == nsr_pkg::NSR_SHORT || mode == nsr_pkg::NSR_LONG) begin
         shaped.data    = IN_W'(y);
         shaped.clipped = clip;
         if (take) begin
            next_ovl = clip | big;
            next_e1  = e;
            next_e2  = e1;
            if (RESET_ON_OVERLOAD_I && (clip || big)) begin
               next_e1 = '0;
               next_e2 = '0;
            end
         end
      end else begin
         next_e1 = '0;
         next_e2 = '0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         e1  <= '0;
         e2  <= '0;
         ovl <= 1'b0;
      end else begin
         e1  <= next_e1;
         e2  <= next_e2;
         ovl <= next_ovl;
      end
   end

   // one sample per clock while the buffer has room
   assign take = IN_VALID_I & buf_ready;

   nsr_buf #(
      .W     ($bits(nsr_pkg::nsr_sample_type)),
      .DEPTH (`NSR_BUF_DEPTH)
   ) u_buf (
      .clk_i       (CORE_CLK_I),
      .rst_i       (RST_I),
      .in_valid_i  (IN_VALID_I),
      .in_data_i   (shaped),
      .in_ready_o  (buf_ready),
      .out_valid_o (OUT_VALID_O),
      .out_data_o  (buf_out),
      .out_ready_i (OUT_READY_I)
   );

   // status and stream outputs
   assign IN_READY_O    = buf_ready;
   assign OUT_DATA_O    = buf_out.data;
   assign OUT_CLIPPED_O = buf_out.clipped;
   assign MODE_O        = mode;
   assign BAND_PCT_O    = band;
   assign CENTER_O      = center;
   assign CONFIG_ERR_O  = cfg_err;
   assign OVERLOAD_O    = ovl;

endmodule

`default_nettype wire

// [rtl/nsr_pkg.sv]
/*
 Types of the noise-shaping requantizer: mode enumeration and the
 packed carrier of one output sample.
 Assumes nsr_consts.svh sits in the include path.
*/
`include "nsr_consts.svh"
`default_nettype none

package nsr_pkg;

   typedef enum logic [1:0] {
      NSR_BYPASS = 2'b00,
      NSR_SHORT  = 2'b01,
      NSR_LONG   = 2'b10,
      NSR_BAD    = 2'b11
   } nsr_mode_type;

   typedef struct packed {
      logic [`NSR_IN_W-1:0] data;
      logic                 clipped;
   } nsr_sample_type;

endpackage

`default_nettype wire

// [verif/nsr_core_sva.sv]
/* checker of the requantizer's port behaviour, bound to nsr_core.
   assumes one clock and a synchronous active-high reset. */
`include "nsr_consts.svh"
`default_nettype none
module nsr_core_sva #(
   parameter int IN_W = 16
) (
   input wire logic                  CORE_CLK_I,
   input wire logic                  RST_I,
   input wire logic                  POST_PROCESSING_OPTIONS_EN_I,
   input wire logic                  SHORT_WORD_EN_I,
   input wire logic                  LONG_WORD_EN_I,
   input wire logic [6:0]            FILTER_SEL_I,
   input wire logic                  RESET_ON_OVERLOAD_I,
   input wire logic                  IN_VALID_I,
   input wire logic [IN_W-1:0]       IN_DATA_I,
   input wire logic                  IN_READY_O,
   input wire logic                  OUT_VALID_O,
   input wire logic [IN_W-1:0]       OUT_DATA_O,
   input wire logic                  OUT_CLIPPED_O,
   input wire logic                  OUT_READY_I,
   input wire nsr_pkg::nsr_mode_type MODE_O,
   input wire logic [4:0]            BAND_PCT_O,
   input wire logic [15:0]           CENTER_O,
   input wire logic                  CONFIG_ERR_O,
   input wire logic                  OVERLOAD_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic take, on_s, on_l;
   // mode requests as the core sees them on this edge
   assign take = IN_VALID_I && IN_READY_O;
   assign on_s = POST_PROCESSING_OPTIONS_EN_I && SHORT_WORD_EN_I
      && !LONG_WORD_EN_I;
   assign on_l = POST_PROCESSING_OPTIONS_EN_I && LONG_WORD_EN_I
      && !SHORT_WORD_EN_I;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   property p_mode_short;
      on_s |=> MODE_O == nsr_pkg::NSR_SHORT;
   endproperty
   a_mode_short: assert property (p_mode_short) else $error("mode");
   property p_mode_off;
      !POST_PROCESSING_OPTIONS_EN_I |=> MODE_O == nsr_pkg::NSR_BYPASS;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("off");
   property p_band22;
      on_s && FILTER_SEL_I <= 7'h14 |=> BAND_PCT_O == 5'h16 && CENTER_O
         == 16'(`NSR_B22_Q16 + `NSR_T22_Q16 * $past(FILTER_SEL_I));
   endproperty
   a_band22: assert property (p_band22) else $error("band22");
   property p_long29;
      on_l && FILTER_SEL_I inside {[7'h3F:7'h4C]} |=> BAND_PCT_O == 5'h1D;
   endproperty
   a_long29: assert property (p_long29) else $error("band29");
   property p_short_err;
      on_s && FILTER_SEL_I > 7'h29 |=> CONFIG_ERR_O;
   endproperty
   a_short_err: assert property (p_short_err) else $error("range");
   property p_bypass;
      take && !OUT_VALID_O && MODE_O == nsr_pkg::NSR_BYPASS
         |=> OUT_VALID_O && OUT_DATA_O == $past(IN_DATA_I);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass");
   property p_short_bits;
      take && !OUT_VALID_O && MODE_O == nsr_pkg::NSR_SHORT
         |=> OUT_VALID_O && OUT_DATA_O[IN_W-12:0] == '0;
   endproperty
   a_short_bits: assert property (p_short_bits) else $error("bits");
   property p_long_bits;
      take && !OUT_VALID_O && MODE_O == nsr_pkg::NSR_LONG
         |=> OUT_VALID_O && OUT_DATA_O[IN_W-13:0] == '0;
   endproperty
   a_long_bits: assert property (p_long_bits) else $error("bits");
   property p_stand;
      OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_DATA_O);
   endproperty
   a_stand: assert property (p_stand) else $error("stall lost");
   c_short: cover property (take && MODE_O == nsr_pkg::NSR_SHORT);
   c_full: cover property (!IN_READY_O);
   c_ovl: cover property (OVERLOAD_O);
endmodule
bind nsr_core nsr_core_sva #(.IN_W(IN_W)) u_chk (.CORE_CLK_I(CORE_CLK_I),
   .RST_I(RST_I), .POST_PROCESSING_OPTIONS_EN_I(POST_PROCESSING_OPTIONS_EN_I),
   .SHORT_WORD_EN_I(SHORT_WORD_EN_I), .LONG_WORD_EN_I(LONG_WORD_EN_I),
   .FILTER_SEL_I(FILTER_SEL_I), .RESET_ON_OVERLOAD_I(RESET_ON_OVERLOAD_I),
   .IN_VALID_I(IN_VALID_I), .IN_DATA_I(IN_DATA_I), .IN_READY_O(IN_READY_O),
   .OUT_VALID_O(OUT_VALID_O), .OUT_DATA_O(OUT_DATA_O),
   .OUT_CLIPPED_O(OUT_CLIPPED_O), .OUT_READY_I(OUT_READY_I),
   .MODE_O(MODE_O), .BAND_PCT_O(BAND_PCT_O), .CENTER_O(CENTER_O),
   .CONFIG_ERR_O(CONFIG_ERR_O), .OVERLOAD_O(OVERLOAD_O));
`default_nettype wire

// [verif/nsr_sink.sv]
/* receiver model of the output stream, queueing each word taken.
   assumes one clock; the bench orders stalls and reads the queue. */
`default_nettype none
module nsr_sink (
   input  wire logic        clk_i,
   input  wire logic        stall_i,
   input  wire logic        valid_i,
   input  wire logic [15:0] data_i,
   output logic             ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] q[$];
   // ready follows the stall order, which changes just after an edge
   assign ready_o = !stall_i;
   // a word is taken only at an edge with both sides high
   always @(posedge clk_i) begin
      if (valid_i && ready_o)
         q.push_back(data_i);
   end
endmodule
`default_nettype wire

// [verif/testbench.sv]
/* bench of nsr_core: bypass, stall, every filter class, range, overload.
   assumes nsr_sink as receiver and the checker bound to the core. */
`include "nsr_consts.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, en, sw, lw, orst, vin, stall;
   logic rdy, vout, clip, cerr, ovl, rdy_in;
   logic [6:0] fsel;
   logic [15:0] din, dout, ctr;
   logic [4:0] band;
   nsr_pkg::nsr_mode_type mode;
   int n_mismatch, check_count;
   nsr_core uut (.CORE_CLK_I(clk), .RST_I(rst),
      .POST_PROCESSING_OPTIONS_EN_I(en), .SHORT_WORD_EN_I(sw),
      .LONG_WORD_EN_I(lw), .FILTER_SEL_I(fsel), .RESET_ON_OVERLOAD_I(orst),
      .IN_VALID_I(vin), .IN_DATA_I(din), .IN_READY_O(rdy_in),
      .OUT_VALID_O(vout), .OUT_DATA_O(dout), .OUT_CLIPPED_O(clip),
      .OUT_READY_I(rdy), .MODE_O(mode), .BAND_PCT_O(band),
      .CENTER_O(ctr), .CONFIG_ERR_O(cerr), .OVERLOAD_O(ovl));
   nsr_sink sink (.clk_i(clk), .stall_i(stall), .valid_i(vout),
      .data_i(dout), .ready_o(rdy));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic conclude;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   // inputs move 2 ns after the edge so no sampling race exists
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic cfg(input logic e, s, l, input logic [6:0] f);
      {en, sw, lw, fsel} = {e, s, l, f};
      cyc(1);
   endtask
   // bounded wait for the take edge; a hang ends the run
   task automatic await_take;
      int k;
      k = 0;
      while (rdy_in !== 1'b1 && k < 50) begin
         cyc(1);
         k++;
      end
      if (k == 50) begin
         n_mismatch++;
         conclude();
      end
      cyc(1);
   endtask
   task automatic send(input logic [15:0] d);
      vin = 1'b1;
      din = d;
      await_take();
   endtask
   // shaped words: low bits cleared, error held within a few LSB
   task automatic pop(input logic [15:0] x, input int drop);
      logic [15:0] y;
      int k;
      k = 0;
      while (sink.q.size() == 0 && k < 50) begin
         cyc(1);
         k++;
      end
      if (k == 50) begin
         n_mismatch++;
         conclude();
      end
      y = sink.q.pop_front();
      k = int'($signed(y)) - int'($signed(x));
      if (drop == 0)
         chk(y, x);
      else
         chk({y & 16'((1 << drop) - 1), k >= -64 && k <= 64}, 1);
   endtask
   function automatic logic [15:0] cexp(input int f);
      if (f <= 20) return 16'(`NSR_B22_Q16 + `NSR_T22_Q16 * f);
      if (f <= 41) return 16'(`NSR_B25_Q16 + `NSR_T25_Q16 * (f - 21));
      if (f <= 62) return 16'(`NSR_B25_Q16 + `NSR_T25_Q16 * (f - 42));
      return 16'(`NSR_B29_Q16 + `NSR_T29_Q16 * (f - 63));
   endfunction
   task automatic t_bypass_stall;
      cfg(1'b0, 1'b1, 1'b0, 7'h05);
      chk(mode, 2'b00);
      stall = 1'b1;
      send(16'h7FFF);
      send(16'h8000);
      din = 16'h0001;
      cyc(2);
      chk({rdy_in, 31'(sink.q.size())}, 0);
      stall = 1'b0;
      await_take();
      vin = 1'b0;
      pop(16'h7FFF, 0);
      pop(16'h8000, 0);
      pop(16'h0001, 0);
   endtask
   // samples kept below 0.9 of full scale here
   task automatic t_filters;
      int fl[8] = '{0, 20, 21, 41, 42, 62, 63, 76};
      for (int i = 0; i < 8; i++) begin
         cfg(1'b1, i < 4, i >= 4, 7'(fl[i]));
         chk(mode, i < 4 ? 2'b01 : 2'b10);
         chk(band, i < 2 ? 22 : i < 6 ? 25 : 29);
         chk(ctr, cexp(fl[i]));
         chk(cerr, 1'b0);
         send(16'hD234);
         vin = 1'b0;
         pop(16'hD234, i < 4 ? 5 : 4);
      end
   endtask
   // out-of-range filters and both word enables at once are set on purpose to see the flag
   task automatic t_range;
      cfg(1'b1, 1'b1, 1'b0, 7'h2A);
      chk(cerr, 1'b1);
      cfg(1'b1, 1'b0, 1'b1, 7'h29);
      chk(cerr, 1'b1);
      cfg(1'b1, 1'b1, 1'b1, 7'h05);
      chk({mode, cerr}, 3'b111);
      send(16'h8001);
      vin = 1'b0;
      pop(16'h8001, 0);
   endtask
   task automatic t_overload;
      int n;
      n = 0;
      orst = 1'b1;
      cfg(1'b1, 1'b1, 1'b0, 7'h05);
      send(16'h7FF0);
      chk(clip, 1'b1);
      vin = 1'b0;
      repeat (3) begin
         n += int'(ovl === 1'b1);
         cyc(1);
      end
      chk(n, 1);
      pop(16'h7FF0, 5);
      // cleared state: a small word then rounds plainly to zero
      send(16'h0004);
      vin = 1'b0;
      chk(clip, 1'b0);
      pop(16'h0000, 0);
   endtask
   initial begin
      {en, sw, lw, orst, vin, stall, fsel, din} = '0;
      n_mismatch = 0;
      check_count = 0;
      rst = 1'b1;
      cyc(3);
      chk({mode, band, ctr, vout, cerr, ovl, rdy_in}, 1);
      rst = 1'b0;
      t_bypass_stall();
      t_filters();
      t_range();
      t_overload();
      conclude();
   end
endmodule
`default_nettype wire
